// ===== verilog/dcs_pkg.sv
package dcs_pkg;
  // ---------------------------------------------------------------
  // fifo geometry and command fields
  // ---------------------------------------------------------------
  localparam int DEPTH       = 8;
  localparam int IDX_W       = 3;
  localparam int CNT_W       = 16;
  localparam int NCLASS      = 4;
  localparam int CLS_W       = 2;
  localparam int PRIO_W      = 3;
  localparam int MID_W       = 4;
  localparam int BANK_W      = 3;
  localparam int LIM_W       = 8;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [LIM_W-1:0] OLD_LIMIT_RST = 8'hFF;
  localparam int               OLD_SCALE_A   = 16;
  localparam int               OLD_SCALE_B   = 2;
  localparam logic [CNT_W-1:0] CLS_LIMIT_RST = 16'h0040;
  localparam real              CLK_NS        = 20.0;
  typedef enum logic [1:0] {
    DCS_SRC_PRIO = 2'h0,
    DCS_SRC_MID  = 2'h1
  } dcs_src_t;
endpackage : dcs_pkg

// ===== verilog/dcs_slot_if.sv
`timescale 1ns/1ns
// per-entry status shared between fifo store and picker
interface dcs_slot_if;
  logic [dcs_pkg::DEPTH-1:0]  valid;
  logic [dcs_pkg::DEPTH-1:0]  is_wr;
  logic [dcs_pkg::DEPTH-1:0]  hit;
  logic [dcs_pkg::DEPTH-1:0]  cls_exp;
  logic [dcs_pkg::DEPTH-1:0]  old_exp;
  logic [dcs_pkg::CLS_W-1:0]  cls   [dcs_pkg::DEPTH];
  logic [dcs_pkg::CNT_W-1:0]  age   [dcs_pkg::DEPTH];
  modport store (output valid, is_wr, hit, cls_exp, old_exp, cls, age);
  modport pick  (input valid, is_wr, hit, cls_exp, old_exp, cls, age);
endinterface : dcs_slot_if

// ===== verilog/dcs_pick.sv
`timescale 1ns/1ns
// combinational picker: chooses one entry of a kind (read or write)
module dcs_pick (
  dcs_slot_if.pick                slot,
  input  wire logic               want_wr,
  input  wire logic [dcs_pkg::CNT_W-1:0] cls_lim [dcs_pkg::NCLASS],
  output logic                    found,
  output logic [dcs_pkg::IDX_W-1:0] idx
);
  logic [dcs_pkg::CLS_W-1:0] best_cls;
  logic                      any_exp;
  logic [dcs_pkg::CNT_W-1:0] best_lim;
  logic                      sel;
  // ------------------------------------------------------------
  // class gate then hit-first, oldest-first choice
  // ------------------------------------------------------------
  always_comb begin
    any_exp  = 1'b0;
    best_cls = '0;
    best_lim = '1;
    found    = 1'b0;
    idx      = '0;
    sel      = 1'b0;
    // only own kind counts: reads and writes never gate each other
    // smaller limit ranks higher
    for (int i = 0; i < dcs_pkg::DEPTH; i++) begin
      if (slot.valid[i] && slot.is_wr[i] == want_wr && slot.cls_exp[i] &&
          cls_lim[slot.cls[i]] <= best_lim) begin
        any_exp  = 1'b1;
        best_lim = cls_lim[slot.cls[i]];
        best_cls = slot.cls[i];
      end
    end
    // pass 0 oldest past age limit, pass 1 open-bank hit, pass 2 oldest eligible
    // an open-bank hit beats the expired class entry among eligible ones
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < dcs_pkg::DEPTH; i++) begin
        sel = slot.valid[i] && slot.is_wr[i] == want_wr;
        if (p == 0)
          sel = sel && slot.old_exp[i];
        else
          sel = sel && (!any_exp || cls_lim[slot.cls[i]] <= cls_lim[best_cls]);
        if (p == 1) sel = sel && slot.hit[i];
        if (sel && !found) begin
          found = 1'b1;
          idx   = dcs_pkg::IDX_W'(i);
        end else if (sel && found && slot.age[i] > slot.age[idx] &&
                     (p != 0 || slot.old_exp[idx])) begin
          idx = dcs_pkg::IDX_W'(i);
        end
      end
      if (found) break;
    end
  end
endmodule : dcs_pick

// ===== verilog/dcs_sched.sv
`timescale 1ns/1ns
// Functional notes
// - waiting commands are ranked by service class from priority or master id
// - each class has its own programmable wait limit
// - smaller programmed limit means higher class
// - reads and writes arbitrate independently; read expiry never holds writes
// - expired read blocks lower-class reads
// - expired write never blocks reads
// - expired write blocks lower-class writes
// - oldest command is promoted once its age reaches the oldest-command limit
// - oldest-command limit field resets to 0xFF
// - age limit equals field times 16 times 2 clock cycles
// - commands are reordered in the fifo to favour open-bank hits
// - expired read may wait behind a steady stream of lower-class bank-hit writes
module dcs_sched (
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic                       cmd_valid,
  input  wire logic                       cmd_wr,
  input  wire logic [dcs_pkg::PRIO_W-1:0] cmd_prio,
  input  wire logic [dcs_pkg::MID_W-1:0]  cmd_mid,
  input  wire logic [dcs_pkg::BANK_W-1:0] cmd_bank,
  input  wire logic [dcs_pkg::MID_W-1:0]  cmd_tag,
  input  wire logic                       class_src,
  input  wire logic [dcs_pkg::CNT_W-1:0]  class_limit [dcs_pkg::NCLASS],
  input  wire logic                       cfg_load,
  input  wire logic [dcs_pkg::LIM_W-1:0]  cfg_old_limit,
  input  wire logic                       issue_ready,
  output logic                            cmd_ready,
  output logic                            issue_valid,
  output logic                            issue_wr,
  output logic [dcs_pkg::BANK_W-1:0]      issue_bank,
  output logic [dcs_pkg::MID_W-1:0]       issue_tag,
  output logic [dcs_pkg::LIM_W-1:0]       oldest_command_age_limit
);
  dcs_slot_if slot ();
  logic [dcs_pkg::DEPTH-1:0]  valid;
  logic [dcs_pkg::DEPTH-1:0]  is_wr;
  logic [dcs_pkg::CLS_W-1:0]  cls    [dcs_pkg::DEPTH];
  logic [dcs_pkg::BANK_W-1:0] bank   [dcs_pkg::DEPTH];
  logic [dcs_pkg::MID_W-1:0]  tag    [dcs_pkg::DEPTH];
  logic [dcs_pkg::CNT_W-1:0]  age    [dcs_pkg::DEPTH];
  logic [dcs_pkg::BANK_W-1:0] open_bank;
  logic                       open_ok;
  logic                       last_wr;
  logic [dcs_pkg::CNT_W-1:0]  old_cycles;
  logic                       rd_found;
  logic                       wr_found;
  logic [dcs_pkg::IDX_W-1:0]  rd_idx;
  logic [dcs_pkg::IDX_W-1:0]  wr_idx;
  logic                       take_wr;
  logic [dcs_pkg::IDX_W-1:0]  pick_idx;
  logic                       do_issue;
  logic                       do_push;
  logic [dcs_pkg::IDX_W-1:0]  free_idx;
  logic                       free_any;
  logic [dcs_pkg::CLS_W-1:0]  new_cls;

  // ------------------------------------------------------------
  // class derivation
  // ------------------------------------------------------------
  // class from source
  always_comb begin
    if (class_src == 1'(dcs_pkg::DCS_SRC_MID))
      new_cls = cmd_mid[dcs_pkg::CLS_W-1:0];
    else
      new_cls = cmd_prio[dcs_pkg::PRIO_W-1 -: dcs_pkg::CLS_W];
  end

  // ------------------------------------------------------------
  // oldest-command limit field
  // ------------------------------------------------------------
  // reset to FF
  always_ff @(posedge core_clk) begin
    if (!resetn)
      oldest_command_age_limit <= dcs_pkg::OLD_LIMIT_RST;
    else if (cfg_load)
      oldest_command_age_limit <= cfg_old_limit;
  end
  // sixteen bits hold the largest limit, 0xFF x 32 = 8160, with room to spare
  // field x16 x2 cycles
  assign old_cycles = dcs_pkg::CNT_W'(oldest_command_age_limit) *
                      dcs_pkg::CNT_W'(dcs_pkg::OLD_SCALE_A * dcs_pkg::OLD_SCALE_B);

  // ------------------------------------------------------------
  // free slot search and handshake
  // ------------------------------------------------------------
  // lowest free slot wins, so the fill order is fixed and easy to trace
  always_comb begin
    free_any = 1'b0;
    free_idx = '0;
    for (int i = dcs_pkg::DEPTH - 1; i >= 0; i--) begin
      if (!valid[i]) begin
        free_any = 1'b1;
        free_idx = dcs_pkg::IDX_W'(i);
      end
    end
  end
  assign do_push = cmd_valid && cmd_ready;

  // ------------------------------------------------------------
  // per-entry storage and age counters
  // ------------------------------------------------------------
  // one store and one age counter per fifo entry
  genvar g;
  generate
    for (g = 0; g < dcs_pkg::DEPTH; g++) begin : g_ent
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          valid[g] <= 1'b0;
          age[g]   <= '0;
        end else if (do_push && free_idx == dcs_pkg::IDX_W'(g)) begin
          valid[g] <= 1'b1;
          age[g]   <= '0;
        end else begin
          if (do_issue && pick_idx == dcs_pkg::IDX_W'(g))
            valid[g] <= 1'b0;
          if (valid[g] && age[g] != '1)
            age[g] <= age[g] + 1'b1; // saturate, never wrap back to young
        end
      end
      // payload is only read while its entry is valid, so it needs no reset
      always_ff @(posedge core_clk) begin
        if (do_push && free_idx == dcs_pkg::IDX_W'(g)) begin
          is_wr[g] <= cmd_wr;
          cls[g]   <= new_cls;
          bank[g]  <= cmd_bank;
          tag[g]   <= cmd_tag;
        end
      end
      assign slot.cls_exp[g] = valid[g] && age[g] >= class_limit[cls[g]];
      assign slot.old_exp[g] = valid[g] && age[g] >= old_cycles;
      assign slot.hit[g]     = valid[g] && open_ok && bank[g] == open_bank &&
                               is_wr[g] == last_wr;
      assign slot.cls[g]     = cls[g];
      assign slot.age[g]     = age[g];
    end
  endgenerate
  // whole-vector status handed to both pickers
  assign slot.valid = valid;
  assign slot.is_wr = is_wr;

  // ------------------------------------------------------------
  // independent read and write pickers
  // ------------------------------------------------------------
  // separate arbitration
  dcs_pick u_rd (
    .slot    (slot),
    .want_wr (1'b0),
    .cls_lim (class_limit),
    .found   (rd_found),
    .idx     (rd_idx)
  );
  dcs_pick u_wr (
    .slot    (slot),
    .want_wr (1'b1),
    .cls_lim (class_limit),
    .found   (wr_found),
    .idx     (wr_idx)
  );

  // ------------------------------------------------------------
  // read/write choice
  // ------------------------------------------------------------
  // bank-hit stream wins unless only the other kind's pick is past the age limit
  always_comb begin
    if (rd_found && wr_found) begin
      if (slot.old_exp[rd_idx] != slot.old_exp[wr_idx])
        take_wr = slot.old_exp[wr_idx];
      else if (slot.hit[rd_idx] != slot.hit[wr_idx])
        take_wr = slot.hit[wr_idx]; // hit keeps winning, so expired read waits
      else
        take_wr = slot.age[wr_idx] > slot.age[rd_idx];
    end else begin
      take_wr = wr_found;
    end
  end
  // a new pick may load in the same cycle the held issue is taken
  assign pick_idx = take_wr ? wr_idx : rd_idx;
  assign do_issue = (rd_found || wr_found) && (!issue_valid || issue_ready);

  // ------------------------------------------------------------
  // issue register and open-bank tracking
  // ------------------------------------------------------------
  // issue holds a command until taken; the picked entry frees at load
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      issue_valid <= 1'b0;
      issue_wr    <= 1'b0;
      issue_bank  <= '0;
      issue_tag   <= '0;
      open_bank   <= '0;
      open_ok     <= 1'b0;
      last_wr     <= 1'b0;
    end else if (do_issue) begin
      issue_valid <= 1'b1;
      issue_wr    <= take_wr;
      issue_bank  <= bank[pick_idx];
      issue_tag   <= tag[pick_idx];
      open_bank   <= bank[pick_idx];
      open_ok     <= 1'b1;
      last_wr     <= take_wr;
    end else if (issue_ready) begin
      issue_valid <= 1'b0;
    end
  end

  // registered ready: drops at the edge whose push takes the last free slot
  always_ff @(posedge core_clk) begin
    if (!resetn)
      cmd_ready <= 1'b0;
    else
      cmd_ready <= free_any && !(do_push && $countones(~valid) == 1);
  end
endmodule : dcs_sched

// ===== verif/dcs_sched_checker.sv
`timescale 1ns/1ns
// ------------------------------------------------
// port checker for the command scheduler
// ------------------------------------------------
module dcs_sched_checker (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cfg_load,
  input wire logic [7:0] cfg_old_limit,
  input wire logic       issue_ready,
  input wire logic       issue_valid,
  input wire logic       issue_wr,
  input wire logic [2:0] issue_bank,
  input wire logic [3:0] issue_tag,
  input wire logic [7:0] oldest_command_age_limit
);
  logic [4:0] occ;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // commands owed downstream; the issue slot may hold one beyond the fifo
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      occ <= 5'h00;
    end else begin
      occ <= occ + 5'(cmd_valid && cmd_ready) - 5'(issue_valid && issue_ready);
    end
  end
  sequence s_push_empty;
    cmd_valid && cmd_ready && occ == 5'h00 && !issue_valid;
  endsequence
  sequence s_land_pick;
    !issue_valid ##1 issue_valid;
  endsequence
  chk_reset_limit: assert property (
    $rose(resetn) |-> oldest_command_age_limit == 8'hFF && !issue_valid)
    else $error("age limit or issue wrong after reset");
  chk_ready_rise: assert property (
    $rose(resetn) |-> !cmd_ready ##1 cmd_ready)
    else $error("cmd_ready did not rise after reset");
  chk_push_issue: assert property (
    s_push_empty |=> s_land_pick)
    else $error("lone command not issued two edges after push");
  chk_cfg_load: assert property (
    cfg_load |=> oldest_command_age_limit == $past(cfg_old_limit))
    else $error("age limit not loaded");
  chk_limit_hold: assert property (
    !cfg_load |=> $stable(oldest_command_age_limit))
    else $error("age limit changed without load");
  chk_issue_hold: assert property (
    issue_valid && !issue_ready |=> issue_valid && $stable(issue_tag)
      && $stable(issue_bank) && $stable(issue_wr))
    else $error("issue changed while stalled");
  chk_issue_owed: assert property (
    issue_valid |-> occ != 5'h00)
    else $error("issue without a pending command");
  chk_no_overfill: assert property (
    occ <= 5'h09)
    else $error("more commands taken than the fifo holds");
endmodule : dcs_sched_checker

// ===== verif/dcs_ddr_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// memory side: accepts issues promptly or every other cycle
// ------------------------------------------------
module dcs_ddr_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic slow,
  output logic     issue_ready
);
  logic phase;
  // registered ready, so a stall lands one edge late like a real queue
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      issue_ready <= 1'b0;
      phase       <= 1'b0;
    end else begin
      phase       <= ~phase;
      issue_ready <= !stall && (!slow || phase);
    end
  end
endmodule : dcs_ddr_model

// ===== verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        core_clk = 1'b0;
  logic        resetn;
  logic        cmd_valid = 1'b0;
  logic        cmd_wr = 1'b0;
  logic [2:0]  cmd_prio = 3'h0;
  logic [3:0]  cmd_mid = 4'h0;
  logic [2:0]  cmd_bank = 3'h0;
  logic [3:0]  cmd_tag = 4'h0;
  logic        class_src = 1'b0;
  logic [15:0] class_limit [4] = '{16'h0004, 16'h0040, 16'h0100, 16'hFFFF};
  logic        cfg_load = 1'b0;
  logic [7:0]  cfg_old_limit = 8'h00;
  logic        stall;
  logic        slow = 1'b0;
  logic        cmd_ready, issue_ready, issue_valid, issue_wr;
  logic [2:0]  issue_bank;
  logic [3:0]  issue_tag;
  logic [7:0]  oldest_command_age_limit;
  logic [7:0]  got [$];
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  dcs_sched dut (.core_clk, .resetn, .cmd_valid, .cmd_wr, .cmd_prio, .cmd_mid, .cmd_bank,
    .cmd_tag, .class_src, .class_limit, .cfg_load, .cfg_old_limit, .issue_ready, .cmd_ready,
    .issue_valid, .issue_wr, .issue_bank, .issue_tag, .oldest_command_age_limit);
  dcs_ddr_model u_ddr (.core_clk, .resetn, .stall, .slow, .issue_ready);
  always #10 core_clk = ~core_clk;
  // record every issue taken downstream, in order
  always @(posedge core_clk) begin
    if (resetn && issue_valid === 1'b1 && issue_ready === 1'b1)
      got.push_back({issue_wr, issue_bank, issue_tag});
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      $display("timeout after %0d cycles", cyc);
      test_done();
    end
  end
  task chk_val(input string name, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk_val
  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : idle
  task rst;
    resetn = 1'b0;
    stall  = 1'b1;
    idle(6);
    resetn = 1'b1;
    got.delete();
  endtask : rst
  // hold the offer until the edge that sees cmd_ready high
  task push(input logic wr, input logic [2:0] prio, input logic [3:0] mid,
            input logic [2:0] bank, input logic [3:0] tag);
    idle(1);
    cmd_valid = 1'b1;
    cmd_wr    = wr;
    cmd_prio  = prio;
    cmd_mid   = mid;
    cmd_bank  = bank;
    cmd_tag   = tag;
    while (cmd_ready !== 1'b1) idle(1);
    idle(1);
    cmd_valid = 1'b0;
  endtask : push
  // release the stall and compare the order of the three issues
  task drain(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2,
             input string name);
    logic [7:0] exp [3];
    exp   = '{e0, e1, e2};
    stall = 1'b0;
    for (int i = 0; i < 300 && got.size() < 3; i++) @(posedge core_clk);
    #2;
    for (int i = 0; i < 3; i++)
      chk_val("issue", exp[i], got.size() > i ? got[i] : 8'hXX);
    $display("test %s done", name);
  endtask : drain
  // expired high-class command jumps an older bank-hit one of its own kind
  task t_class(input logic wr);
    rst();
    chk_val("age_limit", 8'hFF, oldest_command_age_limit);
    push(wr, 3'h6, 4'h0, 3'h0, 4'h0);
    push(wr, 3'h6, 4'h0, 3'h0, 4'h1);
    push(wr, 3'h0, 4'h0, 3'h5, 4'h2);
    idle(20);
    drain({wr, 3'h0, 4'h0}, {wr, 3'h5, 4'h2}, {wr, 3'h0, 4'h1}, "class");
  endtask : t_class
  // class from master id; expiry of one kind must not hold a bank hit of the other
  task t_write(input logic wr);
    rst();
    class_src = 1'b1;
    slow      = 1'b1;
    push(wr, 3'h0, 4'h3, 3'h2, 4'h0);
    push(~wr, 3'h0, 4'h0, 3'h5, 4'h4);
    push(wr, 3'h0, 4'h3, 3'h2, 4'h5);
    idle(20);
    drain({wr, 3'h2, 4'h0}, {wr, 3'h2, 4'h5}, {~wr, 3'h5, 4'h4}, "kind_free");
    class_src = 1'b0;
    slow      = 1'b0;
  endtask : t_write
  // small age limit: the oldest command beats the class gate
  task t_oldest;
    rst();
    cfg_old_limit = 8'h01;
    cfg_load      = 1'b1;
    idle(1);
    cfg_load      = 1'b0;
    chk_val("age_limit", 8'h01, oldest_command_age_limit);
    push(1'b0, 3'h6, 4'h0, 3'h0, 4'h0);
    push(1'b0, 3'h6, 4'h0, 3'h0, 4'h1);
    idle(10);
    push(1'b0, 3'h0, 4'h0, 3'h5, 4'h2);
    idle(30);
    drain(8'h00, 8'h01, 8'h52, "oldest");
  endtask : t_oldest
  // one held issue plus eight waiting entries: the ninth offer fills the fifo
  task t_full;
    rst();
    for (int i = 0; i < 9; i++) push(1'b0, 3'h6, 4'h0, 3'h1, 4'(i));
    idle(2);
    chk_val("cmd_ready", 8'h00, {7'h00, cmd_ready});
    stall = 1'b0;
    for (int i = 0; i < 300 && got.size() < 9; i++) @(posedge core_clk);
    #2;
    chk_val("issue_count", 8'h09, 8'(got.size()));
    chk_val("cmd_ready", 8'h01, {7'h00, cmd_ready});
    $display("test full done");
  endtask : t_full
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    t_class(1'b0);
    t_class(1'b1);
    t_write(1'b1);
    t_write(1'b0);
    t_oldest();
    t_full();
    test_done();
  end
endmodule : tb_top
bind dcs_sched dcs_sched_checker u_chk (.core_clk, .resetn, .cmd_valid, .cmd_ready, .cfg_load,
  .cfg_old_limit, .issue_ready, .issue_valid, .issue_wr, .issue_bank, .issue_tag,
  .oldest_command_age_limit);
